// [rtl/nand_op_timing_badblock.sv]
// Busy sequencer for array operations and invalid block marking
`timescale 1ns/1ns
module nand_op_timing_badblock #(
  parameter int unsigned LOAD_ECC_CYC = nand_timing_pkg::LOAD_ECC_CYC,
  parameter int unsigned PROG_CYC = nand_timing_pkg::PROG_CYC,
  parameter int unsigned ERASE_CYC = nand_timing_pkg::ERASE_CYC,
  parameter int unsigned PD_EXIT_CYC = nand_timing_pkg::PD_EXIT_CYC,
  parameter int unsigned RST_ERASE_CYC = nand_timing_pkg::RST_ERASE_CYC,
  parameter bit RELOAD_PAGE0 = 1'b0
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic link_clk_in,
  input wire logic cmd_valid_in,
  input wire logic [nand_timing_pkg::OP_W-1:0] cmd_op_in,
  input wire logic [nand_timing_pkg::BLOCK_W-1:0] cmd_block_in,
  input wire logic cmd_ecc_in,
  output logic cmd_ready_out,
  output logic link_busy_out,
  input wire logic reset_pin_n_in,
  input wire logic mark_valid_in,
  input wire logic [nand_timing_pkg::BLOCK_W-1:0] mark_block_in,
  output logic mark_refused_out,
  input wire logic [nand_timing_pkg::BLOCK_W-1:0] query_block_in,
  output logic [7:0] marker_byte_out,
  output logic busy_out,
  output logic powered_down_out,
  output logic ecc_enabled_out,
  output logic [nand_timing_pkg::COUNT_W-1:0] valid_count_out
);
  localparam int unsigned TW = nand_timing_pkg::TIMER_W;
  localparam int unsigned BW = nand_timing_pkg::BLOCK_W;
  localparam int unsigned OW = nand_timing_pkg::OP_W;
  localparam int unsigned CW = nand_timing_pkg::COUNT_W;
  localparam int unsigned HW = OW + BW + 1;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BUSY,
    ST_PD
  } state_e;

  state_e state_q;
  logic [TW-1:0] timer_q;
  logic [TW-1:0] elapsed_q;
  logic [OW-1:0] cur_op_q;
  logic [OW-1:0] aborted_q;
  logic [BW-1:0] cur_block_q;
  logic cur_ecc_q;
  logic ecc_q;
  logic bad_q [nand_timing_pkg::BLOCK_COUNT];
  logic [CW-1:0] valid_cnt_q;
  logic link_rst_s1_q;
  logic link_rst_q;
  logic busy_l1_q;
  logic busy_l2_q;
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_q;
  logic hs_valid;
  logic [HW-1:0] hs_data;
  logic [OW-1:0] op;
  logic [BW-1:0] blk;
  logic arg_ecc;
  logic pin_fall;
  logic reset_req;
  logic accept;
  logic start;
  logic done;
  logic mark_ok;

  // Cycles of a busy period, loaded as count minus one
  function automatic logic [TW-1:0] op_cycles(
    input logic [OW-1:0] o,
    input logic e
  );
    int unsigned n;
    n = nand_timing_pkg::CFG_CYC;
    case (o)
      nand_timing_pkg::OP_LOAD: begin
        n = e ? LOAD_ECC_CYC : nand_timing_pkg::LOAD_CYC;
      end
      nand_timing_pkg::OP_PROGRAM: n = PROG_CYC;
      nand_timing_pkg::OP_ERASE: n = ERASE_CYC;
      nand_timing_pkg::OP_PD_ENTER: n = nand_timing_pkg::PD_ENTRY_CYC;
      nand_timing_pkg::OP_PD_EXIT: n = PD_EXIT_CYC;
      default: n = nand_timing_pkg::CFG_CYC;
    endcase
    return TW'(n - 1);
  endfunction

  // Recovery after reset depends on the interrupted operation
  function automatic logic [TW-1:0] rst_cycles(
    input logic [OW-1:0] o,
    input logic e
  );
    int unsigned n;
    n = nand_timing_pkg::RST_READ_CYC; // [R8]
    if (o == nand_timing_pkg::OP_PROGRAM) begin
      n = nand_timing_pkg::RST_PROG_CYC; // [R8]
    end else if (o == nand_timing_pkg::OP_ERASE) begin
      n = RST_ERASE_CYC; // [R8]
    end
    if (RELOAD_PAGE0) begin
      n = n + (e ? LOAD_ECC_CYC : nand_timing_pkg::LOAD_CYC); // [R10]
    end
    return TW'(n - 1);
  endfunction

  // Link side reset release, asserted at once, freed on the link clock
  always_ff @(posedge link_clk_in or posedge reset_in) begin
    if (reset_in) begin
      link_rst_s1_q <= 1'b1;
      link_rst_q <= 1'b1;
    end else begin
      link_rst_s1_q <= 1'b0;
      link_rst_q <= link_rst_s1_q;
    end
  end

  word_handshake #(
    .W(HW)
  ) u_cmd_cross (
    .src_clk_in(link_clk_in),
    .src_reset_in(link_rst_q),
    .src_valid_in(cmd_valid_in),
    .src_data_in({cmd_op_in, cmd_block_in, cmd_ecc_in}),
    .src_ready_out(cmd_ready_out),
    .dst_clk_in(clk_in),
    .dst_reset_in(reset_in),
    .dst_valid_out(hs_valid),
    .dst_data_out(hs_data)
  );

  assign op = hs_data[HW-1 -: OW];
  assign blk = hs_data[BW:1];
  assign arg_ecc = hs_data[0];

  // Busy level back to the link clock
  always_ff @(posedge link_clk_in or posedge link_rst_q) begin
    if (link_rst_q) begin
      busy_l1_q <= 1'b0;
      busy_l2_q <= 1'b0;
    end else begin
      busy_l1_q <= busy_out;
      busy_l2_q <= busy_l1_q;
    end
  end

  assign link_busy_out = busy_l2_q;

  // Reset pin synchroniser and falling edge
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      pin_q <= 1'b1;
    end else begin
      pin_s1_q <= reset_pin_n_in;
      pin_s2_q <= pin_s1_q;
      pin_q <= pin_s2_q;
    end
  end

  assign pin_fall = pin_q & ~pin_s2_q;

  always_comb begin
    reset_req = pin_fall;
    if (hs_valid && op == nand_timing_pkg::OP_RESET &&
        state_q != ST_PD) begin
      reset_req = 1'b1;
    end
    accept = 1'b0;
    if (hs_valid && state_q == ST_IDLE &&
        op != nand_timing_pkg::OP_PD_EXIT &&
        op != nand_timing_pkg::OP_RESET) begin
      accept = 1'b1;
    end
    if (hs_valid && state_q == ST_PD &&
        op == nand_timing_pkg::OP_PD_EXIT) begin
      accept = 1'b1; // [R7]
    end
    start = reset_req | accept;
    done = (state_q == ST_BUSY) && (timer_q == '0) && !reset_req;
  end

  // Operation sequencer
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= ST_IDLE;
      timer_q <= '0;
      cur_op_q <= nand_timing_pkg::OP_LOAD;
      aborted_q <= nand_timing_pkg::OP_LOAD;
      cur_block_q <= '0;
      cur_ecc_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE, ST_PD: begin
          if (reset_req) begin
            state_q <= ST_BUSY;
            cur_op_q <= nand_timing_pkg::OP_RESET;
            aborted_q <= nand_timing_pkg::OP_LOAD;
            timer_q <= rst_cycles(nand_timing_pkg::OP_LOAD, ecc_q);
          end else if (accept) begin
            state_q <= ST_BUSY;
            cur_op_q <= op;
            cur_block_q <= blk;
            cur_ecc_q <= (op == nand_timing_pkg::OP_CFG_WRITE) ?
                         arg_ecc : ecc_q;
            timer_q <= op_cycles(op, ecc_q); // [R1] [R2] [R3] [R6]
          end
        end
        ST_BUSY: begin
          if (reset_req) begin
            cur_op_q <= nand_timing_pkg::OP_RESET;
            aborted_q <= cur_op_q;
            timer_q <= rst_cycles(cur_op_q, ecc_q); // [R8]
          end else if (timer_q != '0) begin
            timer_q <= timer_q - 1'b1;
          end else if (cur_op_q == nand_timing_pkg::OP_PD_ENTER) begin
            state_q <= ST_PD; // [R6]
          end else begin
            state_q <= ST_IDLE; // [R7]
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Erase holds busy for its whole duration
  assign busy_out = (state_q == ST_BUSY); // [R18]
  assign powered_down_out = (state_q == ST_PD);

  // Configuration write lands when its short busy ends
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ecc_q <= nand_timing_pkg::ECC_RESET;
    end else if (done && cur_op_q == nand_timing_pkg::OP_CFG_WRITE) begin
      ecc_q <= cur_ecc_q; // [R5]
    end
  end

  assign ecc_enabled_out = ecc_q;

  // Factory marking, refused for block 0 or below the valid floor
  assign mark_ok = (mark_block_in != nand_timing_pkg::SAFE_BLOCK) &&
                   (valid_cnt_q > CW'(nand_timing_pkg::MIN_VALID)) &&
                   !bad_q[mark_block_in] && (state_q == ST_IDLE);

  // Blocks start erased and valid; marks are per block only
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < nand_timing_pkg::BLOCK_COUNT; i++) begin
        bad_q[i] <= 1'b0; // [R14]
      end
    end else if (mark_valid_in && mark_ok) begin
      bad_q[mark_block_in] <= 1'b1; // [R11] [R12] [R17]
    end else if (done && cur_op_q == nand_timing_pkg::OP_ERASE) begin
      bad_q[cur_block_q] <= 1'b0; // [R15]
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      valid_cnt_q <= CW'(nand_timing_pkg::BLOCK_COUNT);
      mark_refused_out <= 1'b0;
    end else begin
      mark_refused_out <= mark_valid_in && !mark_ok;
      if (mark_valid_in && mark_ok) begin
        valid_cnt_q <= valid_cnt_q - 1'b1; // [R12]
      end else if (done && cur_op_q == nand_timing_pkg::OP_ERASE &&
                   bad_q[cur_block_q]) begin
        valid_cnt_q <= valid_cnt_q + 1'b1;
      end
    end
  end

  assign valid_count_out = valid_cnt_q;

  // Marker byte of the first main and spare byte of a block
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      marker_byte_out <= nand_timing_pkg::ERASED_BYTE;
    end else if (bad_q[query_block_in]) begin
      marker_byte_out <= nand_timing_pkg::BAD_MARK; // [R13]
    end else begin
      marker_byte_out <= nand_timing_pkg::ERASED_BYTE;
    end
  end

  // Cycles spent in the current busy period
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      elapsed_q <= '0;
    end else if (start) begin
      elapsed_q <= '0;
    end else if (state_q == ST_BUSY) begin
      elapsed_q <= elapsed_q + 1'b1;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  chk_load_plain_time: assert property ( // [R1]
    done && cur_op_q == nand_timing_pkg::OP_LOAD && !cur_ecc_q |->
      elapsed_q == TW'(nand_timing_pkg::LOAD_CYC - 1)
  ) else $error("plain page load length wrong");

  chk_load_ecc_time: assert property ( // [R2]
    done && cur_op_q == nand_timing_pkg::OP_LOAD && cur_ecc_q |->
      elapsed_q == TW'(LOAD_ECC_CYC - 1)
  ) else $error("corrected page load length wrong");

  chk_program_time: assert property ( // [R3]
    done && cur_op_q == nand_timing_pkg::OP_PROGRAM |->
      elapsed_q == TW'(PROG_CYC - 1) &&
      elapsed_q < TW'(nand_timing_pkg::PROG_MAX_CYC)
  ) else $error("program busy length wrong");

  chk_cfg_write_lands: assert property ( // [R5]
    done && cur_op_q == nand_timing_pkg::OP_CFG_WRITE |->
      elapsed_q == TW'(nand_timing_pkg::CFG_CYC - 1)
      ##1 ecc_enabled_out == $past(cur_ecc_q)
  ) else $error("configuration write not applied");

  chk_pd_entry: assert property ( // [R6]
    done && cur_op_q == nand_timing_pkg::OP_PD_ENTER |->
      elapsed_q == TW'(nand_timing_pkg::PD_ENTRY_CYC - 1)
      ##1 powered_down_out && !busy_out
  ) else $error("power-down entry late or missing");

  chk_pd_exit: assert property ( // [R7]
    done && cur_op_q == nand_timing_pkg::OP_PD_EXIT |->
      elapsed_q == TW'(PD_EXIT_CYC - 1) ##1 !busy_out && !powered_down_out
  ) else $error("power-down exit length wrong");

  chk_reset_recovery: assert property ( // [R8]
    done && cur_op_q == nand_timing_pkg::OP_RESET &&
      aborted_q == nand_timing_pkg::OP_PROGRAM && !RELOAD_PAGE0 |->
      elapsed_q == TW'(nand_timing_pkg::RST_PROG_CYC - 1)
  ) else $error("reset recovery length wrong");

  chk_block0_valid: assert property ( // [R11]
    query_block_in == nand_timing_pkg::SAFE_BLOCK |=>
      marker_byte_out == nand_timing_pkg::ERASED_BYTE
  ) else $error("block 0 reported invalid");

  chk_valid_floor: assert property ( // [R12]
    valid_count_out >= CW'(nand_timing_pkg::MIN_VALID)
  ) else $error("valid block count below floor");

  chk_marker_bad: assert property ( // [R13]
    mark_valid_in && mark_ok ##1 query_block_in == $past(mark_block_in)
      |=> marker_byte_out != nand_timing_pkg::ERASED_BYTE
  ) else $error("invalid block shows erased marker");

  chk_erase_busy: assert property ( // [R18]
    accept && op == nand_timing_pkg::OP_ERASE |=>
      busy_out [*8]
  ) else $error("erase not reported busy");

  cov_load_done: cover property (
    done && cur_op_q == nand_timing_pkg::OP_LOAD
  );
  cov_erase_bad: cover property (
    done && cur_op_q == nand_timing_pkg::OP_ERASE && bad_q[cur_block_q]
  );
  cov_pd_cycle: cover property (
    done && cur_op_q == nand_timing_pkg::OP_PD_EXIT
  );
  cov_reset_abort: cover property (
    reset_req && state_q == ST_BUSY
  );
endmodule

// [rtl/nand_timing_pkg.sv]
// Timing, opcode and marker constants for the array sequencer
// Function
// R1: Plain page load done within 25 us
// R2: Corrected page load done within 60 us
// R3: Program, lock, map update within 700 us
// R4: Host programs a page at most 4 times
// R5: Configuration write effective within 50 ns
// R6: Power-down entered within 10 us
// R7: Power-down left within 80 us
// R8: Reset recovery 5/10/500 us by interrupted op
// R9: Host holds reset pin low 1 us
// R10: Page 0 reload adds load time
// R11: Block 0 always valid at delivery
// R12: At least 2008 of 2048 blocks valid
// R13: Invalid block marker bytes are not FFh
// R14: Delivered fully erased with marks set; code resets every block to unmarked and valid
// R15: Erasing invalid block loses its mark
// R16: Host scans markers before program or erase
// R17: Invalid blocks never disturb other blocks
// R18: Busy shown while erase in progress
// R19: Host times out busy at maximum
package nand_timing_pkg;
  localparam int unsigned CLK_NS = 8;
  localparam int unsigned LOAD_NS = 25000;
  localparam int unsigned LOAD_ECC_NS = 60000;
  localparam int unsigned PROG_TYP_NS = 250000;
  localparam int unsigned PROG_MAX_NS = 700000;
  localparam int unsigned CFG_NS = 50;
  localparam int unsigned PD_ENTRY_NS = 10000;
  localparam int unsigned PD_EXIT_NS = 80000;
  localparam int unsigned RST_READ_NS = 5000;
  localparam int unsigned RST_PROG_NS = 10000;
  localparam int unsigned RST_ERASE_NS = 500000;
  localparam int unsigned ERASE_TYP_NS = 2000000;
  localparam int unsigned LOAD_CYC = LOAD_NS / CLK_NS;
  localparam int unsigned LOAD_ECC_CYC = LOAD_ECC_NS / CLK_NS;
  localparam int unsigned PROG_CYC = PROG_TYP_NS / CLK_NS;
  localparam int unsigned PROG_MAX_CYC = PROG_MAX_NS / CLK_NS;
  localparam int unsigned CFG_CYC = CFG_NS / CLK_NS;
  localparam int unsigned PD_ENTRY_CYC = PD_ENTRY_NS / CLK_NS;
  localparam int unsigned PD_EXIT_CYC = PD_EXIT_NS / CLK_NS;
  localparam int unsigned RST_READ_CYC = RST_READ_NS / CLK_NS;
  localparam int unsigned RST_PROG_CYC = RST_PROG_NS / CLK_NS;
  localparam int unsigned RST_ERASE_CYC = RST_ERASE_NS / CLK_NS;
  localparam int unsigned ERASE_CYC = ERASE_TYP_NS / CLK_NS;
  localparam int unsigned TIMER_W = 24;
  localparam int unsigned BLOCK_COUNT = 2048;
  localparam int unsigned MIN_VALID = 2008;
  localparam int unsigned BLOCK_W = 11;
  localparam int unsigned COUNT_W = 12;
  localparam int unsigned OP_W = 3;
  localparam logic [OP_W-1:0] OP_LOAD = 3'h0;
  localparam logic [OP_W-1:0] OP_PROGRAM = 3'h1;
  localparam logic [OP_W-1:0] OP_ERASE = 3'h2;
  localparam logic [OP_W-1:0] OP_CFG_WRITE = 3'h3;
  localparam logic [OP_W-1:0] OP_PD_ENTER = 3'h4;
  localparam logic [OP_W-1:0] OP_PD_EXIT = 3'h5;
  localparam logic [OP_W-1:0] OP_RESET = 3'h6;
  localparam logic [BLOCK_W-1:0] SAFE_BLOCK = 11'h000;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] BAD_MARK = 8'h00;
  localparam logic ECC_RESET = 1'b1;
endpackage

// [rtl/word_handshake.sv]
// Request and acknowledge crossing of one word between two clocks
`timescale 1ns/1ns
module word_handshake #(
  parameter int unsigned W = 8
) (
  input wire logic src_clk_in,
  input wire logic src_reset_in,
  input wire logic src_valid_in,
  input wire logic [W-1:0] src_data_in,
  output logic src_ready_out,
  input wire logic dst_clk_in,
  input wire logic dst_reset_in,
  output logic dst_valid_out,
  output logic [W-1:0] dst_data_out
);
  logic req_q;
  logic [W-1:0] data_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic req_s1_q;
  logic req_s2_q;
  logic ack_q;

  // Source holds the word until the toggle comes back
  assign src_ready_out = (req_q == ack_s2_q);

  always_ff @(posedge src_clk_in or posedge src_reset_in) begin
    if (src_reset_in) begin
      req_q <= 1'b0;
      data_q <= '0;
    end else if (src_valid_in && src_ready_out) begin
      req_q <= ~req_q;
      data_q <= src_data_in;
    end
  end

  always_ff @(posedge src_clk_in or posedge src_reset_in) begin
    if (src_reset_in) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  always_ff @(posedge dst_clk_in or posedge dst_reset_in) begin
    if (dst_reset_in) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
    end else begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
    end
  end

  // Word is stable while the request toggle is outstanding
  always_ff @(posedge dst_clk_in or posedge dst_reset_in) begin
    if (dst_reset_in) begin
      ack_q <= 1'b0;
      dst_valid_out <= 1'b0;
      dst_data_out <= '0;
    end else begin
      dst_valid_out <= (req_s2_q != ack_q);
      if (req_s2_q != ack_q) begin
        ack_q <= req_s2_q;
        dst_data_out <= data_q;
      end
    end
  end
endmodule

// [sim/host_link_model.sv]
// Host side command issuer for the sequencer command link
`timescale 1ns/1ns
module host_link_model (
  input wire logic link_clk_in,
  input wire logic cmd_ready_in,
  output logic cmd_valid_out,
  output logic [nand_timing_pkg::OP_W-1:0] cmd_op_out,
  output logic [nand_timing_pkg::BLOCK_W-1:0] cmd_block_out,
  output logic cmd_ecc_out
);
  int prog_count [int];
  initial begin
    cmd_valid_out = 1'b0;
    cmd_op_out = 3'h7;
    cmd_block_out = 11'h7ff;
    cmd_ecc_out = 1'b0;
  end
  // Holds the request until ready is seen, then scrambles the fields
  task automatic send(input logic [nand_timing_pkg::OP_W-1:0] op,
                      input logic [nand_timing_pkg::BLOCK_W-1:0] blk,
                      input logic ecc);
    int k;
    k = 0;
    if (op === nand_timing_pkg::OP_PROGRAM) begin
      if (prog_count[int'(blk)] >= 4) return;
      prog_count[int'(blk)]++;
    end
    if (op === nand_timing_pkg::OP_ERASE) prog_count[int'(blk)] = 0;
    @(posedge link_clk_in);
    #1;
    cmd_valid_out = 1'b1;
    cmd_op_out = op;
    cmd_block_out = blk;
    cmd_ecc_out = ecc;
    @(negedge link_clk_in);
    while (cmd_ready_in !== 1'b1 && k < 1000) begin
      @(negedge link_clk_in);
      k++;
    end
    @(posedge link_clk_in);
    #1;
    cmd_valid_out = 1'b0;
    cmd_op_out = ~op;
    cmd_block_out = ~blk;
    cmd_ecc_out = ~ecc;
  endtask
endmodule

// [sim/nand_op_timing_badblock_tb_top.sv]
// Self-checking bench for the array busy sequencer
`timescale 1ns/1ns
module nand_op_timing_badblock_tb_top;
  localparam int ECC_N = 20;
  localparam int PROG_N = 30;
  localparam int ERASE_N = 40;
  localparam int EXIT_N = 25;
  localparam int RSTE_N = 50;
  logic clk_in, reset_in, link_clk_in, cmd_valid, cmd_ecc, ready;
  logic [2:0] cmd_op;
  logic [10:0] cmd_block, mark_block, query_block;
  logic link_busy, pin_n, mark_valid, refused, busy, pdown, ecc_en;
  logic [7:0] marker;
  logic [11:0] count;
  int mismatches, comparisons, cycles;
  nand_op_timing_badblock #(.LOAD_ECC_CYC(ECC_N), .PROG_CYC(PROG_N),
    .ERASE_CYC(ERASE_N), .PD_EXIT_CYC(EXIT_N), .RST_ERASE_CYC(RSTE_N)
  ) dut_u (.clk_in(clk_in), .reset_in(reset_in),
    .link_clk_in(link_clk_in), .cmd_valid_in(cmd_valid),
    .cmd_op_in(cmd_op), .cmd_block_in(cmd_block), .cmd_ecc_in(cmd_ecc),
    .cmd_ready_out(ready), .link_busy_out(link_busy),
    .reset_pin_n_in(pin_n), .mark_valid_in(mark_valid),
    .mark_block_in(mark_block), .mark_refused_out(refused),
    .query_block_in(query_block), .marker_byte_out(marker),
    .busy_out(busy), .powered_down_out(pdown), .ecc_enabled_out(ecc_en),
    .valid_count_out(count));
  host_link_model host_u (.link_clk_in(link_clk_in), .cmd_ready_in(ready),
    .cmd_valid_out(cmd_valid), .cmd_op_out(cmd_op),
    .cmd_block_out(cmd_block), .cmd_ecc_out(cmd_ecc));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  initial begin
    link_clk_in = 1'b0;
    #2;
    forever #3 link_clk_in = ~link_clk_in;
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, what,
               seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_in);
      #1;
    end
  endtask
  // Polls busy with a bounded wait, then counts its busy cycles
  task automatic measure(output int n);
    int k;
    k = 0;
    n = 0;
    while (busy !== 1'b1 && k < 100) begin
      tick(1);
      k++;
    end
    while (busy === 1'b1 && n < 5000) begin
      n++;
      if (n == 5) check(link_busy, 1'b1, "link busy");
      tick(1);
    end
  endtask
  task automatic run_op(input logic [2:0] op, input logic [10:0] blk,
                        input logic ecc, input int exp, input string what);
    int n;
    host_u.send(op, blk, ecc);
    measure(n);
    check(n, exp, what);
  endtask
  task automatic mark(input logic [10:0] b, output logic r);
    mark_valid = 1'b1;
    mark_block = b;
    tick(1);
    r = refused;
    mark_valid = 1'b0;
    tick(1);
  endtask
  task automatic query(input logic [10:0] b, input logic [7:0] exp);
    query_block = b;
    tick(1);
    check(marker, exp, "marker byte");
  endtask
  task automatic t_reset_state();
    check(busy, 1'b0, "idle busy");
    check(ready, 1'b1, "ready idle");
    check(pdown, 1'b0, "idle power-down");
    check(ecc_en, nand_timing_pkg::ECC_RESET, "ecc default");
    check(count, 12'h800, "count at delivery");
    query(11'h000, 8'hff);
    $display("test reset_state done");
  endtask
  task automatic t_loads();
    run_op(nand_timing_pkg::OP_LOAD, 11'h000, 1'b0, ECC_N, "ecc load");
    run_op(nand_timing_pkg::OP_CFG_WRITE, 11'h000, 1'b0, 6, "cfg");
    check(ecc_en, 1'b0, "ecc off");
    run_op(nand_timing_pkg::OP_LOAD, 11'h000, 1'b0, 3125, "load");
    run_op(nand_timing_pkg::OP_CFG_WRITE, 11'h000, 1'b1, 6, "cfg");
    check(ecc_en, 1'b1, "ecc on");
    $display("test loads done");
  endtask
  task automatic t_program();
    int n;
    int first;
    bit ok;
    first = 0;
    for (int i = 0; i < 5; i++) begin
      host_u.send(nand_timing_pkg::OP_PROGRAM, 11'h002, 1'b0);
      measure(n);
      if (i == 0) first = n;
      check(n, (i < 4) ? PROG_N : 0, "program");
    end
    ok = first > 0 && first < nand_timing_pkg::PROG_MAX_CYC;
    check(ok, 1'b1, "max");
    $display("test program done");
  endtask
  task automatic t_marks();
    logic r;
    mark(11'h005, r);
    check(r, 1'b0, "mark taken");
    check(count, 12'h7ff, "count after mark");
    query(11'h005, nand_timing_pkg::BAD_MARK);
    query(11'h006, 8'hff);
    mark(11'h000, r);
    check(r, 1'b1, "block 0 refused");
    mark(11'h005, r);
    check(r, 1'b1, "double mark refused");
    run_op(nand_timing_pkg::OP_ERASE, 11'h005, 1'b0, ERASE_N, "erase");
    query(11'h005, 8'hff);
    check(count, 12'h800, "count after erase");
    $display("test marks done");
  endtask
  task automatic t_powerdown();
    run_op(nand_timing_pkg::OP_PD_ENTER, 11'h000, 1'b0, 1250, "pd");
    check(pdown, 1'b1, "in power-down");
    host_u.send(nand_timing_pkg::OP_LOAD, 11'h000, 1'b0);
    tick(20);
    check(busy, 1'b0, "load dropped in power-down");
    run_op(nand_timing_pkg::OP_PD_EXIT, 11'h000, 1'b0, EXIT_N, "exit");
    check(pdown, 1'b0, "out of power-down");
    $display("test powerdown done");
  endtask
  // Aborts an operation by command or pin and times the recovery
  task automatic reset_mid(input logic [2:0] op, input bit pin,
                           input int exp);
    int n;
    n = 0;
    host_u.send(op, 11'h009, 1'b0);
    tick(10);
    if (pin) begin
      pin_n = 1'b0;
    end else begin
      host_u.send(nand_timing_pkg::OP_RESET, 11'h000, 1'b0);
    end
    while (busy === 1'b1 && n < 5000) begin
      tick(1);
      n++;
      if (n == 125) pin_n = 1'b1;
    end
    check(n >= exp + 1 && n <= exp + 7, 1'b1, "recovery");
    check(ecc_en, 1'b1, "ecc kept over reset");
  endtask
  task automatic t_resets();
    reset_mid(nand_timing_pkg::OP_ERASE, 1'b0, RSTE_N);
    reset_mid(nand_timing_pkg::OP_PROGRAM, 1'b1, 1250);
    reset_mid(nand_timing_pkg::OP_LOAD, 1'b0, 625);
    $display("test resets done");
  endtask
  task automatic t_floor();
    logic r;
    int taken;
    taken = 0;
    for (int b = 1; b <= 41; b++) begin
      mark(11'(b), r);
      if (r === 1'b0) taken++;
    end
    check(taken, 40, "marks taken");
    check(count, 12'h7d8, "valid floor");
    query(11'h028, nand_timing_pkg::BAD_MARK);
    query(11'h029, 8'hff);
    $display("test floor done");
  endtask
  initial begin
    mismatches = 0;
    comparisons = 0;
    cycles = 0;
    reset_in = 1'b1;
    pin_n = 1'b1;
    mark_valid = 1'b0;
    mark_block = 11'h000;
    query_block = 11'h000;
    repeat (3) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    tick(5);
    t_reset_state();
    t_loads();
    t_program();
    t_marks();
    t_powerdown();
    t_resets();
    t_floor();
    stop_test();
  end
endmodule
